// file: shared/rcss_params.svh
`ifndef RCSS_PARAMS_SVH
`define RCSS_PARAMS_SVH

// System clock
`define RCSS_CLK_PERIOD_NS 25

// Oscillator start-up delay allowances and PLL lock interval
`define RCSS_TOSCD_FAST_RC_NS 1100
`define RCSS_TOSCD_LOW_RC_NS 70000
`define RCSS_TOSCD_XTAL_NS 1100
`define RCSS_TLOCK_NS 1500000

// Start-up timer length in oscillator periods
`define RCSS_OST_PERIODS 1024
`define RCSS_OST_W 11

// Delay timer width
`define RCSS_TIMER_W 16

// Clock select codes (three-bit field)
`define RCSS_SEL_FAST_RC 3'h0
`define RCSS_SEL_FAST_RC_PLL 3'h1
`define RCSS_SEL_PRI 3'h2
`define RCSS_SEL_PRIPLL 3'h3
`define RCSS_SEL_LOW_RC 3'h5
`define RCSS_SEL_FAST_RC_DIV16 3'h6
`define RCSS_SEL_FAST_RC_DIVN 3'h7

// Primary oscillator modes
`define RCSS_PRI_EXT_CLK 2'h0
`define RCSS_PRI_CRYSTAL 2'h1
`define RCSS_PRI_FAST_CRYSTAL 2'h2

// Current oscillator select field in the oscillator control register
`define RCSS_CUR_SEL_MSB 14
`define RCSS_CUR_SEL_LSB 12

// Number of asynchronous warm reset pins
`define RCSS_WARM_SRC_N 3

`endif

// file: shared/rcss_pkg.sv
`include "rcss_params.svh"

package rcss_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    RCSS_ST_HOLD,
    RCSS_ST_OSCD,
    RCSS_ST_OST,
    RCSS_ST_LOCK,
    RCSS_ST_RUN
  } rcss_state_t;

  // Asynchronous pins, synchronised as one bundle
  typedef struct packed {
    logic por;
    logic brownout;
    logic supply_ok;
    logic osc_clk;
    logic [`RCSS_WARM_SRC_N-1:0] warm;
  } rcss_pins_t;

  // Oscillator configuration word fields
  typedef struct packed {
    logic [2:0] reset_clock_select_bits;
    logic [1:0] primary_mode;
  } rcss_clk_cfg_t;

  // Delay components that a mode needs
  typedef struct packed {
    logic oscd;
    logic ost;
    logic lock;
  } rcss_phases_t;

  // Sequencer state
  typedef struct packed {
    rcss_state_t st;
    logic cold;
    logic warm;
    rcss_clk_cfg_t act;
    logic [2:0] cur_sel;
    logic [15:0] ctrl_img;
    logic hold;
    logic osc_en;
    logic pll_en;
    logic osc_prev;
  } rcss_seq_state_t;

endpackage

// file: src/rcss_sync.sv
`timescale 1ns/1ps

module rcss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import rcss_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rcss_sync_state_t;

  rcss_sync_state_t s_reg;
  rcss_sync_state_t s_next;

  // First stage feeds only the second stage
  always_comb begin
    s_next.meta = d;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stable;
endmodule

// file: src/rcss_timer.sv
`timescale 1ns/1ps

module rcss_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic tick,
  // Status
  output logic zero
);
  import rcss_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } rcss_timer_state_t;

  rcss_timer_state_t s_reg;
  rcss_timer_state_t s_next;

  // Load wins over a tick in the same cycle; count stops at zero
  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.cnt = load_value;
    end else if (tick && (s_reg.cnt != '0)) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign zero = (s_reg.cnt == '0);
endmodule

// file: src/rcss_seq.sv
`timescale 1ns/1ps
`include "rcss_params.svh"

module rcss_seq #(
  parameter int PLL_LOCK_CYCLES = `RCSS_TLOCK_NS / `RCSS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Supply supervisors and reset pins (asynchronous)
  input wire logic por_detect,
  input wire logic brownout_detect,
  input wire logic supply_stable,
  input wire logic [`RCSS_WARM_SRC_N-1:0] warm_reset_pins,
  // Oscillator clock, sampled as a plain input
  input wire logic osc_clk_in,
  // Nonvolatile oscillator configuration word
  input wire rcss_pkg::rcss_clk_cfg_t oscillator_config_word,
  // Core side, same clock
  input wire logic sw_reset_instr,
  input wire logic clock_switch_req,
  input wire logic [2:0] clock_switch_sel,
  // Reset and clock status
  output logic device_reset_hold,
  output logic cold_reset_flag,
  output logic warm_reset_flag,
  output logic [2:0] active_clock_sel,
  output logic [2:0] current_oscillator_select,
  output logic [15:0] oscillator_control_register,
  output logic osc_enable,
  output logic pll_enable
);
  import rcss_pkg::*;

  localparam int TW = `RCSS_TIMER_W;
  localparam int OW = `RCSS_OST_W;
  localparam logic [TW-1:0] OSCD_FAST_RC_CNT = TW'(`RCSS_TOSCD_FAST_RC_NS / `RCSS_CLK_PERIOD_NS);
  localparam logic [TW-1:0] OSCD_LOW_RC_CNT = TW'(`RCSS_TOSCD_LOW_RC_NS / `RCSS_CLK_PERIOD_NS);
  localparam logic [TW-1:0] OSCD_XTAL_CNT = TW'(`RCSS_TOSCD_XTAL_NS / `RCSS_CLK_PERIOD_NS);
  localparam logic [TW-1:0] LOCK_CNT = TW'(PLL_LOCK_CYCLES);
  localparam logic [OW-1:0] OST_CNT = OW'(`RCSS_OST_PERIODS);

  rcss_seq_state_t s_reg;
  rcss_seq_state_t s_next;
  rcss_pins_t pins_s;
  rcss_clk_cfg_t act;
  logic cold_evt;
  logic warm_evt;
  logic osc_tick;
  logic dly_load;
  logic [TW-1:0] dly_value;
  logic dly_zero;
  logic ost_load;
  logic ost_zero;

  // Delay parts per oscillator mode
  function automatic rcss_phases_t mode_phases(input rcss_clk_cfg_t c);
    rcss_phases_t p;
    logic xtal;
    xtal = (c.primary_mode == `RCSS_PRI_CRYSTAL) || (c.primary_mode == `RCSS_PRI_FAST_CRYSTAL);
    p = '{oscd: 1'b1, ost: 1'b0, lock: 1'b0};
    case (c.reset_clock_select_bits)
      `RCSS_SEL_FAST_RC_PLL: p.lock = 1'b1;
      `RCSS_SEL_PRI: begin
        p.oscd = xtal;
        p.ost = xtal;
      end
      `RCSS_SEL_PRIPLL: begin
        p.oscd = xtal;
        p.ost = xtal;
        p.lock = 1'b1;
      end
      default: p.lock = 1'b0;
    endcase
    return p;
  endfunction

  // Start-up delay allowance for the selected source
  function automatic logic [TW-1:0] oscd_cycles(input logic [2:0] sel);
    if (sel == `RCSS_SEL_LOW_RC) begin
      return OSCD_LOW_RC_CNT;
    end else if ((sel == `RCSS_SEL_PRI) || (sel == `RCSS_SEL_PRIPLL)) begin
      return OSCD_XTAL_CNT;
    end else begin
      return OSCD_FAST_RC_CNT;
    end
  endfunction

  // First phase still owed after the given one
  function automatic rcss_state_t phase_after(input rcss_state_t cur,
                                              input rcss_phases_t p);
    rcss_state_t nxt;
    nxt = RCSS_ST_RUN;
    if ((cur == RCSS_ST_HOLD) && p.oscd) begin
      nxt = RCSS_ST_OSCD;
    end else if (((cur == RCSS_ST_HOLD) || (cur == RCSS_ST_OSCD)) && p.ost) begin
      nxt = RCSS_ST_OST;
    end else if ((cur != RCSS_ST_LOCK) && p.lock) begin
      nxt = RCSS_ST_LOCK;
    end
    return nxt;
  endfunction

  // All pins pass two flops before any logic sees them
  rcss_sync #(
    .W($bits(rcss_pins_t))
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({por_detect, brownout_detect, supply_stable, osc_clk_in, warm_reset_pins}),
    .q(pins_s)
  );

  // Cycle timer for start-up delay and PLL lock
  rcss_timer #(
    .W(TW)
  ) u_dly (
    .clk(clk),
    .rst_b(rst_b),
    .load(dly_load),
    .load_value(dly_value),
    .tick(1'b1),
    .zero(dly_zero)
  );

  // Oscillator period counter; oscillator must run below half of clk
  rcss_timer #(
    .W(OW)
  ) u_ost (
    .clk(clk),
    .rst_b(rst_b),
    .load(ost_load),
    .load_value(OST_CNT),
    .tick(osc_tick),
    .zero(ost_zero)
  );

  // Reset source classification
  assign cold_evt = pins_s.por | pins_s.brownout;
  assign warm_evt = (|pins_s.warm) | sw_reset_instr;
  assign osc_tick = pins_s.osc_clk & ~s_reg.osc_prev;
  assign act = '{reset_clock_select_bits: s_reg.cold ?
                   oscillator_config_word.reset_clock_select_bits :
                   s_reg.cur_sel,
                 primary_mode: oscillator_config_word.primary_mode};

  // Next state; a new reset restarts the sequence from any phase
  always_comb begin
    s_next = s_reg;
    dly_load = 1'b0;
    dly_value = '0;
    ost_load = 1'b0;
    s_next.osc_prev = pins_s.osc_clk;
    if (cold_evt) begin
      // Cold source always outranks a simultaneous warm one
      s_next.st = RCSS_ST_HOLD;
      s_next.cold = 1'b1;
      s_next.warm = 1'b0;
      s_next.osc_en = 1'b0;
      s_next.pll_en = 1'b0;
    end else if (warm_evt) begin
      s_next.st = RCSS_ST_HOLD;
      // A warm reset during a cold sequence does not downgrade it
      if (s_reg.st == RCSS_ST_RUN) begin
        s_next.cold = 1'b0;
        s_next.warm = 1'b1;
      end
    end else begin
      case (s_reg.st)
        RCSS_ST_HOLD: begin
          if (pins_s.supply_ok) begin
            s_next.act = act;
            s_next.cur_sel = act.reset_clock_select_bits;
            s_next.osc_en = 1'b1;
            s_next.pll_en = mode_phases(act).lock;
            s_next.st = phase_after(RCSS_ST_HOLD, mode_phases(act));
          end
        end
        RCSS_ST_OSCD: begin
          if (dly_zero) begin
            s_next.st = phase_after(RCSS_ST_OSCD, mode_phases(s_reg.act));
          end
        end
        RCSS_ST_OST: begin
          if (ost_zero) begin
            s_next.st = phase_after(RCSS_ST_OST, mode_phases(s_reg.act));
          end
        end
        RCSS_ST_LOCK: begin
          if (dly_zero) begin
            s_next.st = RCSS_ST_RUN;
          end
        end
        RCSS_ST_RUN: begin
          if (clock_switch_req) begin
            s_next.cur_sel = clock_switch_sel;
          end
        end
        default: s_next.st = RCSS_ST_HOLD;
      endcase
    end
    // Arm the timer of the phase being entered
    if (s_next.st != s_reg.st) begin
      case (s_next.st)
        RCSS_ST_OSCD: begin
          dly_load = 1'b1;
          dly_value = oscd_cycles(s_next.act.reset_clock_select_bits);
        end
        RCSS_ST_OST: ost_load = 1'b1;
        RCSS_ST_LOCK: begin
          dly_load = 1'b1;
          dly_value = LOCK_CNT;
        end
        default: dly_load = 1'b0;
      endcase
    end
    // Release only once every owed phase is done
    s_next.hold = (s_next.st != RCSS_ST_RUN);
    s_next.ctrl_img = '0;
    s_next.ctrl_img[`RCSS_CUR_SEL_MSB:`RCSS_CUR_SEL_LSB] = s_next.cur_sel;
  end

  // Reset starts as a cold sequence so config bits pick the clock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= '{st: RCSS_ST_HOLD, cold: 1'b1, hold: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops
  assign device_reset_hold = s_reg.hold;
  assign cold_reset_flag = s_reg.cold;
  assign warm_reset_flag = s_reg.warm;
  assign active_clock_sel = s_reg.act.reset_clock_select_bits;
  assign current_oscillator_select = s_reg.cur_sel;
  assign oscillator_control_register = s_reg.ctrl_img;
  assign osc_enable = s_reg.osc_en;
  assign pll_enable = s_reg.pll_en;

  // Checker helpers: cycles and oscillator edges spent in a phase
  logic [TW-1:0] ph_cnt;
  logic [OW:0] ost_edges;
  logic leave_ok;
  assign leave_ok = (s_next.st != s_reg.st) && (s_next.st != RCSS_ST_HOLD);

  always_ff @(posedge clk) begin
    if (!rst_b || (s_next.st != s_reg.st)) begin
      ph_cnt <= '0;
      ost_edges <= '0;
    end else begin
      ph_cnt <= ph_cnt + 1'b1;
      ost_edges <= ost_edges + {{OW{1'b0}}, osc_tick};
    end
  end

  AST_CLASS_ONEHOT: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot({s_reg.cold, s_reg.warm}))
    else $error("reset class is not exactly one of cold and warm");

  AST_COLD_SRC: assert property (@(posedge clk) disable iff (!rst_b)
    (pins_s.por || pins_s.brownout) |=> (s_reg.cold && s_reg.hold && s_reg.st == RCSS_ST_HOLD))
    else $error("detector reset not taken as cold");

  AST_COLD_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_HOLD && s_reg.cold) |=>
    (active_clock_sel == $past(oscillator_config_word.reset_clock_select_bits)))
    else $error("cold reset did not use config clock select");

  AST_WARM_SRC: assert property (@(posedge clk) disable iff (!rst_b)
    (!cold_evt && warm_evt && s_reg.st == RCSS_ST_RUN) |=>
    (s_reg.warm && !s_reg.cold && s_reg.hold))
    else $error("warm source not taken as warm reset");

  AST_WARM_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_HOLD && s_reg.warm) |=>
    (active_clock_sel == $past(s_reg.cur_sel)) &&
    (oscillator_control_register[`RCSS_CUR_SEL_MSB:`RCSS_CUR_SEL_LSB] == $past(s_reg.cur_sel)))
    else $error("warm reset changed the clock source");

  AST_HOLD_SUPPLY: assert property (@(posedge clk) disable iff (!rst_b)
    (s_reg.st == RCSS_ST_HOLD && !pins_s.supply_ok) |=> s_reg.hold ##0
    (s_reg.st == RCSS_ST_HOLD))
    else $error("left reset hold without stable supply");

  AST_RELEASE_LAST: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(s_reg.hold) |-> $past(pins_s.supply_ok || s_reg.st != RCSS_ST_HOLD) &&
    $past((s_reg.st == RCSS_ST_HOLD) || ((s_reg.st == RCSS_ST_OST) ? ost_zero : dly_zero)))
    else $error("reset released before clock ready");

  AST_OST_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_OST) |-> (ost_edges == `RCSS_OST_PERIODS))
    else $error("start-up timer did not count the oscillator periods");

  AST_OSCD_TIME: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_OSCD) |->
    (ph_cnt == oscd_cycles(s_reg.act.reset_clock_select_bits)))
    else $error("start-up delay length wrong");

  AST_LOCK_TIME: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_LOCK) |-> (ph_cnt == LOCK_CNT))
    else $error("PLL lock interval length wrong");

  AST_XTAL_PLL_PATH: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_OST &&
     s_reg.act.reset_clock_select_bits == `RCSS_SEL_PRIPLL) |=> (s_reg.st == RCSS_ST_LOCK))
    else $error("crystal PLL mode skipped lock after timer");

  AST_EXT_DIRECT: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_HOLD && mode_phases(act) == 3'b000) |=>
    (s_reg.st == RCSS_ST_RUN) ##0 !device_reset_hold)
    else $error("external clock mode did not release at once");

  AST_FIRST_PHASE: assert property (@(posedge clk) disable iff (!rst_b)
    (leave_ok && s_reg.st == RCSS_ST_HOLD && mode_phases(act) == 3'b001) |=>
    (s_reg.st == RCSS_ST_LOCK))
    else $error("lock-only mode entered the wrong phase");
endmodule

// file: tb/rcss_supply_model.sv
`timescale 1ns/1ps

// Supply supervisors and oscillator as the sequencer sees them
module rcss_supply_model #(
  parameter int RAMP = 10,
  parameter real OSC_HALF_NS = 55.0
) (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic supply_on,
  input wire logic brownout_req,
  input wire logic osc_enable,
  // Supervisor and oscillator outputs
  output logic por_detect,
  output logic brownout_detect,
  output logic supply_stable,
  output logic osc_clk_in
);
  int ramp_cnt = 0;

  // Power-on detector stays up until the supply ramp has settled
  initial begin
    por_detect = 1'h1;
    brownout_detect = 1'h0;
    supply_stable = 1'h0;
    osc_clk_in = 1'h0;
  end

  // A brownout also drops the stable flag, as a sagging rail would
  always @(posedge clk) begin
    ramp_cnt <= supply_on ? ((ramp_cnt < RAMP) ? ramp_cnt + 1 : RAMP) : 0;
    por_detect <= (ramp_cnt < RAMP);
    brownout_detect <= brownout_req;
    supply_stable <= (ramp_cnt == RAMP) && !brownout_req;
  end

  // Oscillator stands still while disabled, so no edge is counted early
  always #(OSC_HALF_NS) osc_clk_in = osc_enable ? !osc_clk_in : 1'h0;
endmodule

// file: tb/rcss_seq_bench.sv
`timescale 1ns/1ps

module rcss_seq_bench;
  import rcss_pkg::*;
  localparam int LOCK = 20;
  // 1024 periods of a 110 ns oscillator, in 25 ns cycles
  localparam int OST = 1024 * 110 / 25;
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] pm;
    logic use_brownout;
    logic pll;
  } rcss_row_t;
  // Rows: select, primary mode, cold source, expected pll enable
  rcss_row_t rows [11] = '{
    '{3'h0, 2'h0, 1'h0, 1'h0}, '{3'h1, 2'h0, 1'h1, 1'h1}, '{3'h2, 2'h0, 1'h0, 1'h0},
    '{3'h2, 2'h1, 1'h1, 1'h0}, '{3'h2, 2'h2, 1'h0, 1'h0}, '{3'h3, 2'h0, 1'h1, 1'h1},
    '{3'h3, 2'h1, 1'h0, 1'h1}, '{3'h3, 2'h2, 1'h1, 1'h1}, '{3'h5, 2'h0, 1'h0, 1'h0},
    '{3'h6, 2'h0, 1'h1, 1'h0}, '{3'h7, 2'h0, 1'h0, 1'h0}};
  logic [2:0] wsel [4] = '{3'h5, 3'h1, 3'h6, 3'h0};
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic supply_on = 1'h0;
  logic brownout_req = 1'h0;
  logic sw_reset_instr = 1'h0;
  logic [2:0] warm_reset_pins = 3'h0;
  logic clock_switch_req = 1'h0;
  logic [2:0] clock_switch_sel = 3'h0;
  rcss_clk_cfg_t cfg = '0;
  logic por_detect, brownout_detect, supply_stable, osc_clk_in;
  logic device_reset_hold, cold_reset_flag, warm_reset_flag, osc_enable, pll_enable;
  logic [2:0] active_clock_sel, current_oscillator_select;
  logic [15:0] oscillator_control_register;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  rcss_supply_model rcss_supply_model_inst (.clk(clk), .supply_on(supply_on),
    .brownout_req(brownout_req), .osc_enable(osc_enable), .por_detect(por_detect),
    .brownout_detect(brownout_detect), .supply_stable(supply_stable),
    .osc_clk_in(osc_clk_in));

  rcss_seq #(.PLL_LOCK_CYCLES(LOCK)) rcss_seq_inst (.clk(clk), .rst_b(rst_b),
    .por_detect(por_detect), .brownout_detect(brownout_detect),
    .supply_stable(supply_stable),
    .warm_reset_pins(warm_reset_pins), .osc_clk_in(osc_clk_in),
    .oscillator_config_word(cfg), .sw_reset_instr(sw_reset_instr),
    .clock_switch_req(clock_switch_req), .clock_switch_sel(clock_switch_sel),
    .device_reset_hold(device_reset_hold), .cold_reset_flag(cold_reset_flag),
    .warm_reset_flag(warm_reset_flag), .active_clock_sel(active_clock_sel),
    .current_oscillator_select(current_oscillator_select),
    .oscillator_control_register(oscillator_control_register),
    .osc_enable(osc_enable), .pll_enable(pll_enable));

  // Clock and a cycle ceiling well above the longest crystal sequences
  always #12.5 clk = !clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic step();
    @(posedge clk);
    #2;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected hold length per select and primary mode
  function automatic int exp_delay(input logic [2:0] s, input logic [1:0] p);
    logic xtal;
    xtal = (p == 2'h1) || (p == 2'h2);
    case (s)
      3'h1: return 45 + LOCK + 1;
      3'h2: return xtal ? 45 + OST : 0;
      3'h3: return xtal ? 45 + OST + LOCK + 1 : LOCK + 1;
      3'h5: return 2801;
      default: return 45;
    endcase
  endfunction

  // Waits for the supply supervisors to go quiet, then times the hold; crystals get slack for phase
  task automatic run_seq(input int d, input int slack);
    int n;
    n = 0;
    do step(); while (!(supply_stable === 1'h1 && por_detect === 1'h0 &&
                        brownout_detect === 1'h0));
    while (device_reset_hold !== 1'h0 && n < 20000) begin
      step();
      n++;
    end
    n_compared++;
    if (n < d - 2 - slack || n > d + 6 + slack) begin
      num_errors++;
      $display("CHECK FAILED hold cycles expected %0d seen %0d", d + 3, n);
    end
  endtask

  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) step();
    check("hold in reset", 16'h1, 16'(device_reset_hold));
    check("cold in reset", 16'h1, 16'({warm_reset_flag, cold_reset_flag}));
    check("control reg in reset", 16'h0, oscillator_control_register);
    check("osc enable in reset", 16'h0, 16'({osc_enable, pll_enable}));
    rst_b = 1'h1;
    repeat (200) step();
    check("hold without supply", 16'h1, 16'(device_reset_hold));
    // Cold sequence for every mode, power-on and brownout in turn
    foreach (rows[i]) begin
      cfg.reset_clock_select_bits = rows[i].sel;
      cfg.primary_mode = rows[i].pm;
      brownout_req = rows[i].use_brownout;
      supply_on = rows[i].use_brownout;
      repeat (5) step();
      brownout_req = 1'h0;
      supply_on = 1'h1;
      run_seq(exp_delay(rows[i].sel, rows[i].pm),
        (rows[i].sel[1] && rows[i].pm != 2'h0 && rows[i].pm != 2'h3) ? 8 : 0);
      check("cold flags", 16'h1, 16'({warm_reset_flag, cold_reset_flag}));
      check("active select", 16'(rows[i].sel), 16'(active_clock_sel));
      check("control reg", {1'h0, rows[i].sel, 12'h000}, oscillator_control_register);
      check("pll enable", 16'(rows[i].pll), 16'(pll_enable));
      check("osc enable", 16'h1, 16'(osc_enable));
    end
    // Warm sources keep the switched clock
    for (int k = 0; k < 4; k++) begin
      clock_switch_sel = wsel[k];
      clock_switch_req = 1'h1;
      step();
      clock_switch_req = 1'h0;
      check("switched reg", {1'h0, wsel[k], 12'h000}, oscillator_control_register);
      {sw_reset_instr, warm_reset_pins} = 4'h1 << k;
      repeat (3) step();
      {sw_reset_instr, warm_reset_pins} = 4'h0;
      run_seq(exp_delay(wsel[k], cfg.primary_mode), 0);
      check("warm flags", 16'h2, 16'({warm_reset_flag, cold_reset_flag}));
      check("warm select", 16'(wsel[k]), 16'(active_clock_sel));
    end
    // Cold with warm together, then warm and a switch in mid-sequence
    cfg = '0;
    supply_on = 1'h0;
    warm_reset_pins = 3'h1;
    repeat (5) step();
    supply_on = 1'h1;
    warm_reset_pins = 3'h0;
    repeat (20) step();
    clock_switch_sel = 3'h5;
    clock_switch_req = 1'h1;
    sw_reset_instr = 1'h1;
    step();
    clock_switch_req = 1'h0;
    sw_reset_instr = 1'h0;
    run_seq(45, 0);
    check("mixed flags", 16'h1, 16'({warm_reset_flag, cold_reset_flag}));
    check("switch ignored", 16'h0, 16'(current_oscillator_select));
    end_sim();
  end
endmodule
